// >>> verilog/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_MODE      = 8'h00;
    localparam logic [7:0] OFS_CTRL_ONE  = 8'h04;
    localparam logic [7:0] OFS_CTRL_TWO  = 8'h08;
    localparam logic [7:0] OFS_AUX_CTRL  = 8'h0C;
    localparam logic [7:0] OFS_CUR_SRC   = 8'h10;
    localparam logic [7:0] OFS_DEC_WORD  = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;
    localparam logic [7:0] OFS_MASK      = 8'h1C;
    localparam logic [7:0] OFS_PRI_DATA  = 8'h20;
    localparam logic [7:0] OFS_AUX_DATA  = 8'h24;
    localparam logic [7:0] OFS_PRI_OFS   = 8'h28;
    localparam logic [7:0] OFS_PRI_GAIN  = 8'h2C;
    localparam logic [7:0] OFS_AUX_OFS   = 8'h30;
    localparam logic [7:0] OFS_AUX_GAIN  = 8'h34;

    // Mode register fields
    localparam int MODE_NOTCH_BIT    = 6;
    localparam int MODE_CHOP_OFF_BIT = 3;
    localparam int MODE_SEL_LSB      = 0;
    localparam int MODE_SEL_W        = 3;

    // Mode select encodings
    localparam logic [2:0] MSEL_IDLE     = 3'h0;
    localparam logic [2:0] MSEL_CONVERT  = 3'h1;
    localparam logic [2:0] MSEL_PRI_OFS  = 3'h2;
    localparam logic [2:0] MSEL_PRI_GAIN = 3'h3;
    localparam logic [2:0] MSEL_AUX_OFS  = 3'h4;
    localparam logic [2:0] MSEL_AUX_GAIN = 3'h5;

    // Control register fields
    localparam int BUF_LSB        = 6;
    localparam int BUF_W          = 2;
    localparam int CHAN_LSB       = 0;
    localparam int CHAN_W         = 3;
    localparam int PRI_BANDGAP    = 7;
    localparam int PRI_SECOND_REF = 6;
    localparam int AUX_BANDGAP    = 6;
    localparam int BURNOUT_BIT    = 6;

    // Channel codes of the burnout-capable pairs
    localparam logic [2:0] CHAN_PAIR_45 = 3'h4;
    localparam logic [2:0] CHAN_PAIR_67 = 3'h6;

    // Status bits
    localparam int ST_PRI_READY = 0;
    localparam int ST_AUX_READY = 1;
    localparam int ST_REF_MISS  = 2;
    localparam int ST_PRI_ERR   = 3;
    localparam int ST_AUX_ERR   = 4;
    localparam int ST_CAL_DONE  = 5;
    localparam int ST_W         = 6;

    // Decimation word limits and reset value
    localparam logic [7:0] DEC_MIN_NOCHOP = 8'h03;
    localparam logic [7:0] DEC_MIN_CHOP   = 8'h0D;
    localparam logic [7:0] DEC_RESET      = 8'h45;
    localparam logic [7:0] DEC_NOTCH_MIN  = 8'h44;

    // Result width and clamp value
    localparam int          RES_W     = 24;
    localparam logic [23:0] RES_CLAMP = 24'hFFFFFF;

    // Controller states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CONV  = 3'b010,
        ST_CALIB = 3'b100
    } ctl_state_e;
endpackage

// >>> verilog/filter_if.sv
`timescale 1ns/1ps
// Links the controller with the decimation sequencer
interface filter_if;
    logic [7:0] dec_word;    // Stored decimation word
    logic       chop_off;    // Chopping disabled
    logic       notch_on;    // Extra notch requested
    logic       run;         // Conversions running
    logic [7:0] eff_word;    // Decimation factor in use
    logic       notch_act;   // Extra notch really applied
    logic       conv_done;   // One-cycle pulse per result

    modport ctl (output dec_word, chop_off, notch_on, run,
                 input eff_word, notch_act, conv_done);
    modport flt (input dec_word, chop_off, notch_on, run,
                 output eff_word, notch_act, conv_done);
endinterface

// >>> verilog/sinc_decimator.sv
`timescale 1ns/1ps
// Counts modulator ticks per decimated result
module sinc_decimator
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Modulator clock pin
    input  wire logic mod_clk,
    // Controller side
    filter_if.flt     fif
);
    // Lower bound of the word depends on chop mode
    function automatic logic [7:0] clamp_word(input logic [7:0] w,
                                              input logic       off);
        logic [7:0] lo;
        lo = off ? DEC_MIN_NOCHOP : DEC_MIN_CHOP;
        clamp_word = (w < lo) ? lo : w;
    endfunction

    logic [1:0] mod_sync_q;  // Two-stage synchroniser
    logic       mod_prev_q;  // Previous synced level
    logic [7:0] cnt_q;       // Ticks inside this filter word
    logic       half_q;      // Set after the first of two chopped words
    logic       done_q;      // Result pulse
    wire        tick;        // Rising modulator edge
    wire        word_end;    // Filter output word complete

    assign tick = mod_sync_q[1] & ~mod_prev_q;
    // Clamp applies in the filter, not to the stored word
    assign fif.eff_word = clamp_word(fif.dec_word,
                                     fif.chop_off);
    assign word_end = tick && (cnt_q >= fif.eff_word - 8'h01);
    // Notch only honoured from word DEC_NOTCH_MIN (8'h44) upward
    assign fif.notch_act = fif.notch_on &&
                           (fif.eff_word >= DEC_NOTCH_MIN);
    assign fif.conv_done = done_q;

    // Synchronise the modulator clock pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_sync_q <= 2'h0;
            mod_prev_q <= 1'b0;
        end else begin
            mod_sync_q <= {mod_sync_q[0], mod_clk};
            mod_prev_q <= mod_sync_q[1];
        end
    end

    // Decimation counter; chopped results span two words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 8'h00;
            half_q <= 1'b0;
            done_q <= 1'b0;
        end else if (!fif.run) begin
            cnt_q  <= 8'h00;
            half_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= word_end && (fif.chop_off || half_q);
            if (word_end) begin
                cnt_q  <= 8'h00;
                half_q <= fif.chop_off ? 1'b0 : ~half_q;
            end else if (tick) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule

// >>> verilog/adc_ref_ctrl.sv
`timescale 1ns/1ps
module adc_ref_ctrl
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Analog front end
    input  wire logic                mod_clk,
    input  wire logic                ref_pos_ok,
    input  wire logic                ref_neg_ok,
    input  wire logic [RES_W-1:0]    pri_raw,
    input  wire logic [RES_W-1:0]    aux_raw,
    // Analog controls
    output logic                     pri_use_bandgap,
    output logic                     pri_use_second_ref,
    output logic                     aux_use_bandgap,
    output logic                     pri_range_halved,
    output logic                     aux_range_halved,
    output logic                     burnout_pair45_on,
    output logic                     burnout_pair67_on,
    output logic                     chop_on,
    output logic                     notch_60hz_on,
    // Interrupt
    output logic                     irq
);
    import adc_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////
    filter_if   fif ();                    // Link to the decimator
    ctl_state_e state_q;                   // Controller state
    ctl_state_e state_d;                   // Next state
    logic [7:0] mode_q;                    // Converter mode register
    logic [7:0] ctrl_one_q;                // Buffer and channel
    logic [7:0] ctrl_two_q;                // Primary reference select
    logic [7:0] aux_ctrl_q;                // Aux reference select
    logic [7:0] cur_src_q;                 // Current source control
    logic [7:0] dec_word_q;                // Decimation word
    logic [ST_W-1:0]  status_q;            // Sticky status
    logic [ST_W-1:0]  mask_q;              // Interrupt mask
    logic [RES_W-1:0] pri_data_q;          // Primary result
    logic [RES_W-1:0] aux_data_q;          // Aux result
    logic [RES_W-1:0] pri_ofs_q;           // Primary offset cal
    logic [RES_W-1:0] pri_gain_q;          // Primary gain cal
    logic [RES_W-1:0] aux_ofs_q;           // Aux offset cal
    logic [RES_W-1:0] aux_gain_q;          // Aux gain cal
    logic [1:0] ref_sync_q;                // First stage per pin
    logic [1:0] ref_ok_q;                  // Second stage per pin
    logic       cal_bad_q;                 // Reference lost in cal
    logic [31:0] rdata_d;                  // Read mux
    logic        hit_any;                  // Address is mapped

    ////////////////////////////////////////////////////////////////////
    // Decode
    ////////////////////////////////////////////////////////////////////
    // True when a write access targets the given offset
    function automatic logic wr_hit(input logic [7:0] ofs,
                                    input logic [7:0] adr,
                                    input logic       we);
        wr_hit = we && (adr == ofs);
    endfunction

    // Zero-extends a register into a bus word
    function automatic logic [31:0] word8(input logic [7:0] v);
        word8 = {24'h000000, v};
    endfunction

    wire       access   = psel & penable;
    wire       wr_en    = access & pwrite & hit_any;
    wire [2:0] msel     = mode_q[MODE_SEL_LSB +: MODE_SEL_W];
    wire       chan45   = ctrl_one_q[CHAN_LSB +: CHAN_W] == CHAN_PAIR_45;
    wire       chan67   = ctrl_one_q[CHAN_LSB +: CHAN_W] == CHAN_PAIR_67;
    wire       buf_on   = |ctrl_one_q[BUF_LSB +: BUF_W];
    wire       burn_req = cur_src_q[BURNOUT_BIT] & buf_on;
    // Only the first reference pins are watched
    wire       ref_miss = ~(ref_ok_q[0] & ref_ok_q[1]);
    wire       is_cal   = (msel == MSEL_PRI_OFS) ||
                          (msel == MSEL_PRI_GAIN) ||
                          (msel == MSEL_AUX_OFS) ||
                          (msel == MSEL_AUX_GAIN);
    wire       cal_aux  = (msel == MSEL_AUX_OFS) ||
                          (msel == MSEL_AUX_GAIN);
    wire       cal_end  = (state_q == ST_CALIB) & fif.conv_done;
    wire       cal_fail = cal_end & (cal_bad_q | ref_miss);
    wire       cal_ok   = cal_end & ~(cal_bad_q | ref_miss);
    wire       conv_end = (state_q == ST_CONV) & fif.conv_done;
    wire [RES_W-1:0] pri_res = ref_miss ? RES_CLAMP : pri_raw;
    wire [RES_W-1:0] aux_res = ref_miss ? RES_CLAMP : aux_raw;

    ////////////////////////////////////////////////////////////////////
    // Status events
    ////////////////////////////////////////////////////////////////////
    wire [ST_W-1:0] st_set;                // Hardware events
    wire [ST_W-1:0] st_clr;                // Write-one-to-clear

    assign st_set[ST_PRI_READY] = conv_end;
    assign st_set[ST_AUX_READY] = conv_end;
    assign st_set[ST_REF_MISS]  = ref_miss;
    assign st_set[ST_PRI_ERR]   = cal_fail & ~cal_aux;
    assign st_set[ST_AUX_ERR]   = cal_fail & cal_aux;
    assign st_set[ST_CAL_DONE]  = cal_end;
    assign st_clr = wr_hit(OFS_STATUS, paddr, wr_en) ?
                    pwdata[ST_W-1:0] : {ST_W{1'b0}};

    ////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////
    assign pri_use_bandgap    = ctrl_two_q[PRI_BANDGAP];
    // Second reference only reachable from the primary side
    assign pri_use_second_ref = ~ctrl_two_q[PRI_BANDGAP] &
                                ctrl_two_q[PRI_SECOND_REF];
    assign aux_use_bandgap    = aux_ctrl_q[AUX_BANDGAP];
    assign pri_range_halved   = ctrl_two_q[PRI_BANDGAP];
    assign aux_range_halved   = aux_ctrl_q[AUX_BANDGAP];
    assign burnout_pair45_on  = burn_req & chan45;
    assign burnout_pair67_on  = burn_req & chan67;
    assign chop_on            = ~mode_q[MODE_CHOP_OFF_BIT];
    assign notch_60hz_on      = fif.notch_act;
    assign irq                = |(status_q & mask_q);
    assign pready             = 1'b1;
    assign pslverr            = access & ~hit_any;

    ////////////////////////////////////////////////////////////////////
    // Decimator hookup
    ////////////////////////////////////////////////////////////////////
    // Calibration uses the same word software programmed
    assign fif.dec_word = dec_word_q;
    assign fif.chop_off = mode_q[MODE_CHOP_OFF_BIT];
    assign fif.notch_on = mode_q[MODE_NOTCH_BIT];
    assign fif.run      = (state_q != ST_IDLE);

    sinc_decimator u_dec (
        .pclk    (pclk),
        .presetn (presetn),
        .mod_clk (mod_clk),
        .fif     (fif)
    );

    ////////////////////////////////////////////////////////////////////
    // Read mux
    ////////////////////////////////////////////////////////////////////
    // Unmapped addresses read zero and raise pslverr
    always_comb begin
        hit_any = 1'b1;
        rdata_d = 32'h00000000;
        case (paddr)
            OFS_MODE:     rdata_d = word8(mode_q);
            OFS_CTRL_ONE: rdata_d = word8(ctrl_one_q);
            OFS_CTRL_TWO: rdata_d = word8(ctrl_two_q);
            OFS_AUX_CTRL: rdata_d = word8(aux_ctrl_q);
            OFS_CUR_SRC:  rdata_d = word8(cur_src_q);
            OFS_DEC_WORD: rdata_d = word8(dec_word_q);
            OFS_STATUS:   rdata_d = {26'h0000000, status_q};
            OFS_MASK:     rdata_d = {26'h0000000, mask_q};
            OFS_PRI_DATA: rdata_d = {8'h00, pri_data_q};
            OFS_AUX_DATA: rdata_d = {8'h00, aux_data_q};
            OFS_PRI_OFS:  rdata_d = {8'h00, pri_ofs_q};
            OFS_PRI_GAIN: rdata_d = {8'h00, pri_gain_q};
            OFS_AUX_OFS:  rdata_d = {8'h00, aux_ofs_q};
            OFS_AUX_GAIN: rdata_d = {8'h00, aux_gain_q};
            default:      hit_any = 1'b0;
        endcase
    end

    // Read data held in a flop, updated on each read access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !pwrite) begin
            prdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reference pin synchroniser
    ////////////////////////////////////////////////////////////////////
    // Two flops per comparator level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_sync_q <= 2'h0;
            ref_ok_q   <= 2'h0;
        end else begin
            ref_sync_q <= {ref_neg_ok, ref_pos_ok};
            ref_ok_q   <= ref_sync_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Controller state machine
    ////////////////////////////////////////////////////////////////////
    // Mode select drives idle, conversion or calibration
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (is_cal) begin
                    state_d = ST_CALIB;
                end else if (msel == MSEL_CONVERT) begin
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (msel != MSEL_CONVERT) begin
                    state_d = ST_IDLE;
                end
            end
            ST_CALIB: begin
                if (cal_end || !is_cal) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Remembers a reference loss anywhere inside a calibration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_bad_q <= 1'b0;
        end else if (state_q != ST_CALIB) begin
            cal_bad_q <= 1'b0;
        end else if (ref_miss) begin
            cal_bad_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control registers
    ////////////////////////////////////////////////////////////////////
    // Software writes; mode select returns to idle after calibration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q     <= 8'h00;
            ctrl_one_q <= 8'h00;
            ctrl_two_q <= 8'h00;
            aux_ctrl_q <= 8'h00;
            cur_src_q  <= 8'h00;
            dec_word_q <= DEC_RESET;
            mask_q     <= {ST_W{1'b0}};
        end else begin
            if (wr_hit(OFS_MODE, paddr, wr_en)) begin
                mode_q <= pwdata[7:0];
            end else if (cal_end) begin
                mode_q[MODE_SEL_LSB +: MODE_SEL_W] <= MSEL_IDLE;
            end
            if (wr_hit(OFS_CTRL_ONE, paddr, wr_en)) begin
                ctrl_one_q <= pwdata[7:0];
            end
            if (wr_hit(OFS_CTRL_TWO, paddr, wr_en)) begin
                ctrl_two_q <= pwdata[7:0];
            end
            if (wr_hit(OFS_AUX_CTRL, paddr, wr_en)) begin
                aux_ctrl_q <= pwdata[7:0];
            end
            if (wr_hit(OFS_CUR_SRC, paddr, wr_en)) begin
                cur_src_q <= pwdata[7:0];
            end
            if (wr_hit(OFS_DEC_WORD, paddr, wr_en)) begin
                dec_word_q <= pwdata[7:0];
            end
            if (wr_hit(OFS_MASK, paddr, wr_en)) begin
                mask_q <= pwdata[ST_W-1:0];
            end
        end
    end

    // Sticky status; a new event beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= {ST_W{1'b0}};
        end else begin
            status_q <= (status_q & ~st_clr) | st_set;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Results and calibration coefficients
    ////////////////////////////////////////////////////////////////////
    // Coefficients load only when the reference stayed valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pri_data_q <= {RES_W{1'b0}};
            aux_data_q <= {RES_W{1'b0}};
            pri_ofs_q  <= {RES_W{1'b0}};
            pri_gain_q <= {RES_W{1'b0}};
            aux_ofs_q  <= {RES_W{1'b0}};
            aux_gain_q <= {RES_W{1'b0}};
        end else begin
            if (conv_end) begin
                pri_data_q <= pri_res;
                aux_data_q <= aux_res;
            end
            if (cal_ok) begin
                case (msel)
                    MSEL_PRI_OFS:  pri_ofs_q  <= pri_raw;
                    MSEL_PRI_GAIN: pri_gain_q <= pri_raw;
                    MSEL_AUX_OFS:  aux_ofs_q  <= aux_raw;
                    MSEL_AUX_GAIN: aux_gain_q <= aux_raw;
                    default:       pri_ofs_q  <= pri_ofs_q;
                endcase
            end
        end
    end
endmodule

// >>> sim/adc_ref_ctrl_checker.sv
`timescale 1ns/1ps
// Ties control outputs to the bus writes that cause them
module adc_ref_ctrl_checker
    import adc_ctrl_pkg::*;
(
    // Clock, reset and bus
    input wire logic        pclk, presetn, psel, penable, pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // Analog controls
    input wire logic pri_use_bandgap, pri_use_second_ref, aux_use_bandgap,
    input wire logic pri_range_halved, aux_range_halved, chop_on,
    input wire logic burnout_pair45_on, burnout_pair67_on, notch_60hz_on
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A write completing at one offset
    sequence s_wr(logic [7:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    AST_PRI_HALF: assert property (pri_range_halved == pri_use_bandgap)
        else $error("primary range flag wrong");
    AST_AUX_HALF: assert property (aux_range_halved == aux_use_bandgap)
        else $error("aux range flag wrong");
    AST_REF_EXCL: assert property (pri_use_bandgap |->
        !pri_use_second_ref)
        else $error("two references routed");
    AST_PAIR_EXCL: assert property (
        !(burnout_pair45_on && burnout_pair67_on))
        else $error("both pairs burning");
    AST_BG_WR: assert property (s_wr(OFS_CTRL_TWO) ##0 pwdata[7]
        |=> pri_use_bandgap)
        else $error("band gap not routed");
    AST_AUX_WR: assert property (s_wr(OFS_AUX_CTRL) ##0 !pwdata[6]
        |=> !aux_use_bandgap)
        else $error("aux band gap stuck");
    AST_CHOP_OFF: assert property (s_wr(OFS_MODE) ##0 pwdata[3]
        |=> !chop_on)
        else $error("chop not disabled");
    AST_CHOP_ON: assert property (s_wr(OFS_MODE) ##0 !pwdata[3]
        |=> chop_on)
        else $error("chop not enabled");
    AST_NOTCH_WR: assert property (s_wr(OFS_MODE) ##0 !pwdata[6]
        |=> !notch_60hz_on)
        else $error("notch left on");
    AST_BURN_WR: assert property (s_wr(OFS_CUR_SRC) ##0 !pwdata[6]
        |=> !burnout_pair45_on && !burnout_pair67_on)
        else $error("burnout left on");
    AST_BUF_WR: assert property (s_wr(OFS_CTRL_ONE) ##0 !pwdata[7:6]
        |=> !burnout_pair45_on && !burnout_pair67_on)
        else $error("burnout without buffer");
endmodule
bind adc_ref_ctrl adc_ref_ctrl_checker adc_ref_ctrl_checker_inst (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pri_use_bandgap,
    .pri_use_second_ref, .aux_use_bandgap, .pri_range_halved,
    .aux_range_halved, .chop_on, .burnout_pair45_on, .burnout_pair67_on,
    .notch_60hz_on);

// >>> sim/ref_sensor_model.sv
`timescale 1ns/1ps
// External reference, bridge sensor and modulator clock
module ref_sensor_model (
    // Bench control
    input  wire logic   ref_connect,
    // Device pins
    output logic        mod_clk,
    output logic        ref_pos_ok,
    output logic        ref_neg_ok,
    output logic [23:0] pri_raw,
    output logic [23:0] aux_raw
);
    // Modulator runs free, ten bus clocks per tick
    // Notch is only a flag here, so no true modulator rate is needed
    initial mod_clk = 1'b0;
    always #125 mod_clk = ~mod_clk;
    // Unplugged cable drops both pins below threshold
    assign ref_pos_ok = ref_connect;
    assign ref_neg_ok = ref_connect;
    // Steady bridge words, neither zero nor full scale: a healthy sensor
    assign pri_raw = 24'h123456;
    assign aux_raw = 24'h654321;
endmodule

// >>> sim/adc_ref_ctrl_test.sv
`timescale 1ns/1ps
module adc_ref_ctrl_test;
    import adc_ctrl_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r, o;
    logic ref_connect = 1, mod_clk, ref_pos_ok, ref_neg_ok, pready, pslverr;
    logic [23:0] pri_raw, aux_raw;
    logic pri_use_bandgap, pri_use_second_ref, aux_use_bandgap, irq, chop_on;
    logic pri_range_halved, aux_range_halved, notch_60hz_on;
    logic burnout_pair45_on, burnout_pair67_on;
    int num_errors = 0, checks = 0, cyc = 0, t0;
    // Write table: offset, data, expected control vector
    localparam logic [7:0] TA [14] = '{OFS_CTRL_TWO, OFS_CTRL_TWO,
        OFS_AUX_CTRL, OFS_CTRL_ONE, OFS_CUR_SRC, OFS_CTRL_ONE, OFS_CTRL_ONE,
        OFS_CTRL_ONE, OFS_MODE, OFS_MODE, OFS_DEC_WORD, OFS_MODE,
        OFS_DEC_WORD, OFS_DEC_WORD};
    localparam logic [7:0] TD [14] = '{8'h80, 8'h40, 8'h40, 8'h04, 8'h40,
        8'hC4, 8'hC6, 8'hC5, 8'h48, 8'h08, 8'h43, 8'h40, 8'h44, 8'h02};
    localparam logic [8:0] TV [14] = '{9'h122, 9'h082, 9'h0D2, 9'h0D2,
        9'h0D2, 9'h0DA, 9'h0D6, 9'h0D2, 9'h0D1, 9'h0D0, 9'h0D0, 9'h0D2,
        9'h0D3, 9'h0D2};
    always #12.5 pclk = ~pclk;
    ref_sensor_model ref_sensor_model_inst (.ref_connect, .mod_clk,
        .ref_pos_ok, .ref_neg_ok, .pri_raw, .aux_raw);
    adc_ref_ctrl adc_ref_ctrl_inst (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mod_clk,
        .ref_pos_ok, .ref_neg_ok, .pri_raw, .aux_raw, .pri_use_bandgap,
        .pri_use_second_ref, .aux_use_bandgap, .pri_range_halved,
        .aux_range_halved, .burnout_pair45_on, .burnout_pair67_on, .chop_on,
        .notch_60hz_on, .irq);
    // Verdict and end of run
    task end_sim;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Compare one value
    task chk(input string n, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    // One APB transfer; read data and error taken at the ready edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Next edge with interrupt high; the cycle limit ends a hang
    task wait_irq;
        do @(posedge pclk); while (irq !== 1'b1);
    endtask
    // Interval between two results against ticks times ten clocks
    task period(input logic [7:0] m, w, input int e);
        xfer(1, OFS_DEC_WORD, {24'h0, w});
        xfer(1, OFS_MODE, {24'h0, m});
        xfer(1, OFS_STATUS, 32'h3F);
        wait_irq;
        t0 = cyc;
        xfer(1, OFS_STATUS, 32'h3F);
        wait_irq;
        t0 = cyc - t0;
        chk("period", 32'(e), 32'((t0 > e - 4 && t0 < e + 4) ? e : t0));
    endtask
    // Cycle limit
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            end_sim;
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        xfer(0, OFS_DEC_WORD, 0);
        chk("dec_reset", 32'h45, r);
        for (int i = 0; i < 14; i++) begin
            xfer(1, TA[i], {24'h0, TD[i]});
            // Let the register update of the ready edge settle
            @(negedge pclk);
            chk("controls", {23'h0, TV[i]}, {23'h0,
                pri_use_bandgap, pri_use_second_ref, aux_use_bandgap,
                pri_range_halved, aux_range_halved, burnout_pair45_on,
                burnout_pair67_on, chop_on, notch_60hz_on});
        end
        xfer(0, OFS_DEC_WORD, 0);
        chk("dec_stored", 32'h02, r);
        xfer(0, 8'hFC, 0);
        chk("unmapped", 32'h1, {31'h0, se});
        $display("done: register controls");
        xfer(1, OFS_MASK, 32'h01);
        period(8'h09, 8'h02, 30);
        period(8'h01, 8'h02, 260);
        period(8'h09, 8'h05, 50);
        period(8'h09, 8'hFF, 2550);
        $display("done: decimation");
        xfer(1, OFS_DEC_WORD, 32'h03);
        xfer(1, OFS_MASK, 32'h04);
        ref_connect <= 0;
        wait_irq;
        xfer(1, OFS_MASK, 32'h01);
        xfer(1, OFS_STATUS, 32'h3F);
        wait_irq;
        xfer(0, OFS_PRI_DATA, 0);
        chk("clamped", 32'hFFFFFF, r);
        xfer(0, OFS_PRI_OFS, 0);
        o = r;
        xfer(1, OFS_MASK, 32'h20);
        for (int k = 0; k < 2; k++) begin
            xfer(1, OFS_MODE, 32'h0A);
            xfer(1, OFS_STATUS, 32'h3F);
            wait_irq;
            xfer(0, OFS_STATUS, 0);
            chk("cal_err", 32'(k == 0), {31'h0, r[ST_PRI_ERR]});
            chk("irq", 32'h1, {31'h0, irq});
            xfer(0, OFS_PRI_OFS, 0);
            chk("offset", k == 0 ? o : 32'h123456, r);
            ref_connect <= 1;
            repeat (6) @(posedge pclk);
        end
        $display("done: reference detect");
        end_sim;
    end
endmodule
